//--- design/crs_pkg.sv
// shared constants, types and state layout for the cpu register set
package crs_pkg;
  // -----------------------------------------------------------------
  // widths and counts
  // -----------------------------------------------------------------
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned ACC_W      = 64;
  localparam int unsigned GPR_COUNT  = 16;
  localparam int unsigned GPR_AW     = 4;
  localparam int unsigned WB_AW      = 8;
  localparam int unsigned WB_SW      = 4;

  // -----------------------------------------------------------------
  // status word fields and reset values
  // -----------------------------------------------------------------
  localparam int unsigned SW_STACK_SEL_BIT = 17;
  localparam logic [31:0] SW_RESET   = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [63:0] ACC_RESET  = 64'h0000_0000_0000_0000;

  // -----------------------------------------------------------------
  // wishbone word offsets (byte address = index * 4)
  // -----------------------------------------------------------------
  localparam logic [4:0] IDX_GPR_LAST = 5'h0F;
  localparam logic [4:0] IDX_ISP      = 5'h10;
  localparam logic [4:0] IDX_USP      = 5'h11;
  localparam logic [4:0] IDX_VTB      = 5'h12;
  localparam logic [4:0] IDX_IP       = 5'h13;
  localparam logic [4:0] IDX_SW       = 5'h14;
  localparam logic [4:0] IDX_SIP      = 5'h15;
  localparam logic [4:0] IDX_SSW      = 5'h16;
  localparam logic [4:0] IDX_FAST_IRQ_TARGET    = 5'h17;
  localparam logic [4:0] IDX_ACC_HI   = 5'h18;
  localparam logic [4:0] IDX_ACC_LO   = 5'h19;
  localparam logic [4:0] IDX_ACC_MID  = 5'h1A;

  // -----------------------------------------------------------------
  // core-side commands
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    CTL_VTB   = 3'h0,
    CTL_IP    = 3'h1,
    CTL_SW    = 3'h2,
    CTL_SIP   = 3'h3,
    CTL_SSW   = 3'h4,
    CTL_FAST_IRQ_TARGET = 3'h5,
    CTL_ISP   = 3'h6,
    CTL_USP   = 3'h7
  } crs_ctl_e;

  typedef enum logic [1:0] {
    ACC_NONE    = 2'h0,
    ACC_PRODUCT = 2'h1,
    ACC_WR_HI   = 2'h2,
    ACC_WR_LO   = 2'h3
  } crs_acc_e;

  typedef struct packed {
    logic              we;
    logic [3:0]        addr;
    logic [31:0]       data;
  } crs_gpr_wr_s;

  typedef struct packed {
    logic              we;
    crs_ctl_e          sel;
    logic [31:0]       data;
  } crs_ctl_wr_s;

  typedef struct packed {
    crs_acc_e          op;
    logic [63:0]       data;
  } crs_acc_wr_s;

  typedef struct packed {
    logic [15:1][31:0] gpr;
    logic [31:0]       irq_stack_ptr;
    logic [31:0]       thread_stack_ptr;
    logic [31:0]       vtb;
    logic [31:0]       ip;
    logic [31:0]       sw;
    logic [31:0]       sip;
    logic [31:0]       ssw;
    logic [31:0]       fast_irq_target;
    logic [63:0]       acc;
    logic              ack;
    logic [31:0]       rdat;
    logic [31:0]       rdA;
    logic [31:0]       rdB;
  } crs_state_s;
endpackage : crs_pkg

//--- design/crs_register_set.sv
// programmer-visible cpu register set with core ports and a wishbone slave
`timescale 1ns/100ps

// Overview of operation
// RULE_01: sixteen general registers, two read ports and one write port for operands.
// RULE_02: register zero is the stack pointer, sharing its storage.
// RULE_03: stack pointer maps to interrupt or thread copy by status select bit.
// RULE_04: software should keep both stack copies aligned to four.
// RULE_05: vector table base register holds the relocatable vector table start.
// RULE_06: instruction pointer holds the address of the executing instruction.
// RULE_07: status word holds results and operating state of the core.
// RULE_08: taking a fast interrupt copies instruction pointer into its saved copy.
// RULE_09: taking a fast interrupt copies status word into saved status, same layout.
// RULE_10: taking a fast interrupt branches to the fast interrupt target address.
// RULE_11: a 64-bit wide product register exists for signal processing.
// RULE_12: product operations overwrite the whole wide product register.
// RULE_13: upper and lower half writes load bits 63:32 and 31:0.
// RULE_14: upper read returns bits 63:32, middle read returns bits 47:16.
// RULE_15: fast interrupt return restores instruction pointer and status, hence stack bank.
module crs_register_set (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [3:0]            gprRdAddrA,
  input  wire logic [3:0]            gprRdAddrB,
  output logic      [31:0]           gprRdDataA,
  output logic      [31:0]           gprRdDataB,
  input  wire crs_pkg::crs_gpr_wr_s  gprWr,
  input  wire crs_pkg::crs_ctl_wr_s  ctlWr,
  input  wire crs_pkg::crs_acc_wr_s  accWr,
  input  wire logic                  fastIrqTake,
  input  wire logic                  fastIrqReturn,
  output logic      [31:0]           vectorTableBase,
  output logic      [31:0]           instrPointer,
  output logic      [31:0]           statusWord,
  output logic      [31:0]           accUpperRead,
  output logic      [31:0]           accMiddleRead
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  crs_pkg::crs_state_s q;
  crs_pkg::crs_state_s d;

  // reset image built from the package values except gpr and ack, which are literal zeros
  localparam crs_pkg::crs_state_s STATE_RESET = '{
    gpr:   '0,
    irq_stack_ptr:   crs_pkg::WORD_RESET,
    thread_stack_ptr:   crs_pkg::WORD_RESET,
    vtb:   crs_pkg::WORD_RESET,
    ip:    crs_pkg::WORD_RESET,
    sw:    crs_pkg::SW_RESET,
    sip:   crs_pkg::WORD_RESET,
    ssw:   crs_pkg::SW_RESET,
    fast_irq_target: crs_pkg::WORD_RESET,
    acc:   crs_pkg::ACC_RESET,
    ack:   1'b0,
    rdat:  crs_pkg::WORD_RESET,
    rdA:   crs_pkg::WORD_RESET,
    rdB:   crs_pkg::WORD_RESET
  };

  logic [4:0]  busIdx;
  logic        busWrite;
  logic [31:0] busRead;
  logic        threadSel;

  assign busIdx    = wb_adr_i[6:2];
  // the write lands on the edge where the master samples ack
  assign busWrite  = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
  assign threadSel = q.sw[crs_pkg::SW_STACK_SEL_BIT];

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  // address zero never reaches the general array: it is the banked stack pointer
  function automatic logic [31:0] gprView(input crs_pkg::crs_state_s s, input logic [3:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == 4'h0) begin
      r = s.sw[crs_pkg::SW_STACK_SEL_BIT] ? s.thread_stack_ptr : s.irq_stack_ptr; // [RULE_02] [RULE_03]
    end else begin
      r = s.gpr[a];
    end
    return r;
  endfunction : gprView

  // -----------------------------------------------------------------
  // bus read decode; unmapped words read as zero
  // -----------------------------------------------------------------
  always_comb begin
    busRead = 32'h0000_0000;
    if (busIdx <= crs_pkg::IDX_GPR_LAST) begin
      busRead = gprView(q, busIdx[3:0]);
    end else begin
      case (busIdx)
        crs_pkg::IDX_ISP:     busRead = q.irq_stack_ptr;
        crs_pkg::IDX_USP:     busRead = q.thread_stack_ptr;
        crs_pkg::IDX_VTB:     busRead = q.vtb;
        crs_pkg::IDX_IP:      busRead = q.ip;
        crs_pkg::IDX_SW:      busRead = q.sw;
        crs_pkg::IDX_SIP:     busRead = q.sip;
        crs_pkg::IDX_SSW:     busRead = q.ssw;
        crs_pkg::IDX_FAST_IRQ_TARGET:   busRead = q.fast_irq_target;
        crs_pkg::IDX_ACC_HI:  busRead = q.acc[63:32];
        crs_pkg::IDX_ACC_LO:  busRead = q.acc[31:0];
        crs_pkg::IDX_ACC_MID: busRead = q.acc[47:16];
        default:              busRead = 32'h0000_0000;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // next state: bus, then core ports, then fast interrupt (highest)
  // -----------------------------------------------------------------
  always_comb begin
    d = q;
    // a strobe in the ack cycle is not a new request; the master idles a cycle
    d.ack  = wb_cyc_i & wb_stb_i & ~q.ack;
    d.rdat = (wb_cyc_i & wb_stb_i & ~q.ack) ? busRead : q.rdat;
    // operand reads are registered, so data follows the address by one cycle
    d.rdA  = gprView(q, gprRdAddrA); // [RULE_01]
    d.rdB  = gprView(q, gprRdAddrB); // [RULE_01]

    if (busWrite) begin
      if (busIdx <= crs_pkg::IDX_GPR_LAST) begin
        if (busIdx[3:0] == 4'h0) begin
          if (threadSel) begin
            d.thread_stack_ptr = mergeBytes(q.thread_stack_ptr, wb_dat_i, wb_sel_i);
          end else begin
            d.irq_stack_ptr = mergeBytes(q.irq_stack_ptr, wb_dat_i, wb_sel_i);
          end
        end else begin
          d.gpr[busIdx[3:0]] = mergeBytes(q.gpr[busIdx[3:0]], wb_dat_i, wb_sel_i);
        end
      end else begin
        case (busIdx)
          crs_pkg::IDX_ISP:    d.irq_stack_ptr = mergeBytes(q.irq_stack_ptr, wb_dat_i, wb_sel_i);
          crs_pkg::IDX_USP:    d.thread_stack_ptr = mergeBytes(q.thread_stack_ptr, wb_dat_i, wb_sel_i);
          crs_pkg::IDX_VTB:    d.vtb = mergeBytes(q.vtb, wb_dat_i, wb_sel_i);
          crs_pkg::IDX_IP:     d.ip = mergeBytes(q.ip, wb_dat_i, wb_sel_i);
          crs_pkg::IDX_SW:     d.sw = mergeBytes(q.sw, wb_dat_i, wb_sel_i);
          crs_pkg::IDX_SIP:    d.sip = mergeBytes(q.sip, wb_dat_i, wb_sel_i);
          crs_pkg::IDX_SSW:    d.ssw = mergeBytes(q.ssw, wb_dat_i, wb_sel_i);
          crs_pkg::IDX_FAST_IRQ_TARGET:  d.fast_irq_target = mergeBytes(q.fast_irq_target, wb_dat_i, wb_sel_i);
          crs_pkg::IDX_ACC_HI: d.acc[63:32] = mergeBytes(q.acc[63:32], wb_dat_i, wb_sel_i);
          crs_pkg::IDX_ACC_LO: d.acc[31:0] = mergeBytes(q.acc[31:0], wb_dat_i, wb_sel_i);
          default:             d.ack = d.ack; // read-only or unmapped: write ignored
        endcase
      end
    end

    if (gprWr.we) begin
      if (gprWr.addr == 4'h0) begin
        if (threadSel) begin
          d.thread_stack_ptr = gprWr.data; // [RULE_02] [RULE_03]
        end else begin
          d.irq_stack_ptr = gprWr.data; // [RULE_02] [RULE_03]
        end
      end else begin
        d.gpr[gprWr.addr] = gprWr.data; // [RULE_01]
      end
    end

    if (ctlWr.we) begin
      unique case (ctlWr.sel)
        crs_pkg::CTL_VTB:   d.vtb = ctlWr.data; // [RULE_05]
        crs_pkg::CTL_IP:    d.ip = ctlWr.data; // [RULE_06]
        crs_pkg::CTL_SW:    d.sw = ctlWr.data; // [RULE_07]
        crs_pkg::CTL_SIP:   d.sip = ctlWr.data;
        crs_pkg::CTL_SSW:   d.ssw = ctlWr.data;
        crs_pkg::CTL_FAST_IRQ_TARGET: d.fast_irq_target = ctlWr.data;
        crs_pkg::CTL_ISP:   d.irq_stack_ptr = ctlWr.data;
        crs_pkg::CTL_USP:   d.thread_stack_ptr = ctlWr.data;
      endcase
    end

    unique case (accWr.op)
      crs_pkg::ACC_NONE:    d.acc = d.acc;
      crs_pkg::ACC_PRODUCT: d.acc = accWr.data; // [RULE_11] [RULE_12]
      crs_pkg::ACC_WR_HI:   d.acc[63:32] = accWr.data[31:0]; // [RULE_13]
      crs_pkg::ACC_WR_LO:   d.acc[31:0] = accWr.data[31:0]; // [RULE_13]
    endcase

    // take beats return; the saved copies avoid a memory push
    if (fastIrqTake) begin
      d.sip = q.ip; // [RULE_08]
      d.ssw = q.sw; // [RULE_09]
      d.ip  = q.fast_irq_target; // [RULE_10]
      d.sw[crs_pkg::SW_STACK_SEL_BIT] = 1'b0;
    end else if (fastIrqReturn) begin
      d.ip = q.sip; // [RULE_15]
      d.sw = q.ssw; // [RULE_15]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all taken straight from the state flops
  // -----------------------------------------------------------------
  assign wb_dat_o        = q.rdat;
  assign wb_ack_o        = q.ack;
  assign gprRdDataA      = q.rdA;
  assign gprRdDataB      = q.rdB;
  assign vectorTableBase = q.vtb;
  assign instrPointer    = q.ip;
  assign statusWord      = q.sw;
  assign accUpperRead    = q.acc[63:32]; // [RULE_14]
  assign accMiddleRead   = q.acc[47:16]; // [RULE_14]

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  // same-cycle writers of higher priority are excluded where they would win
  a_fast_save_ip: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_08]
    fastIrqTake |=> q.sip == $past(q.ip)) else $error("saved ip not captured");
  a_fast_save_sw: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_09]
    fastIrqTake |=> q.ssw == $past(q.sw)) else $error("saved status not captured");
  a_fast_branch_target: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_10]
    fastIrqTake |=> instrPointer == $past(q.fast_irq_target)) else $error("no branch to fast target");
  a_return_restores_state: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_15]
    (fastIrqReturn && !fastIrqTake) |=> (instrPointer == $past(q.sip)) && (statusWord == $past(q.ssw)))
    else $error("return did not restore");
  a_bank_select_read: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_03]
    (gprRdAddrA == 4'h0) |=> gprRdDataA == ($past(threadSel) ? $past(q.thread_stack_ptr) : $past(q.irq_stack_ptr)))
    else $error("stack bank mux wrong");
  a_gpr_zero_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_02]
    (gprWr.we && gprWr.addr == 4'h0 && !threadSel && !(ctlWr.we && ctlWr.sel == crs_pkg::CTL_ISP))
    |=> q.irq_stack_ptr == $past(gprWr.data)) else $error("gpr zero write missed stack");
  a_product_overwrite: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_12]
    accWr.op == crs_pkg::ACC_PRODUCT |=> {accUpperRead, q.acc[31:0]} == $past(accWr.data))
    else $error("product did not overwrite");
  a_upper_half_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_13]
    (accWr.op == crs_pkg::ACC_WR_HI && !busWrite) |=> accUpperRead == $past(accWr.data[31:0]) &&
    q.acc[31:0] == $past(q.acc[31:0])) else $error("upper half write wrong");
  a_middle_read_window: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_14]
    accMiddleRead[31:16] == accUpperRead[15:0]) else $error("middle window misaligned");
  a_bus_ack_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");
  a_vtb_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_05]
    (ctlWr.we && ctlWr.sel == crs_pkg::CTL_VTB) |=> vectorTableBase == $past(ctlWr.data))
    else $error("vector base write lost");
  a_lower_half_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_13]
    (accWr.op == crs_pkg::ACC_WR_LO && !busWrite) |=> q.acc[31:0] == $past(accWr.data[31:0]) &&
    accUpperRead == $past(accUpperRead)) else $error("lower half write wrong");
  a_gpr_write_read: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_01]
    (gprWr.we && gprWr.addr != 4'h0) |=> q.gpr[$past(gprWr.addr)] == $past(gprWr.data))
    else $error("general register write lost");
  a_ip_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_06]
    (ctlWr.we && ctlWr.sel == crs_pkg::CTL_IP && !fastIrqTake && !fastIrqReturn)
    |=> instrPointer == $past(ctlWr.data)) else $error("instruction pointer write lost");
  a_sw_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_07]
    (ctlWr.we && ctlWr.sel == crs_pkg::CTL_SW && !fastIrqTake && !fastIrqReturn)
    |=> statusWord == $past(ctlWr.data)) else $error("status word write lost");
  a_take_clears_bank: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_03]
    fastIrqTake |=> !threadSel) else $error("take left thread stack active");
  a_ack_follows_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing after strobe");
  a_bank_select_b: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_03]
    (gprRdAddrB == 4'h0) |=> gprRdDataB == ($past(threadSel) ? $past(q.thread_stack_ptr) : $past(q.irq_stack_ptr)))
    else $error("stack bank mux wrong on port b");
  a_unmapped_read_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (wb_cyc_i && wb_stb_i && !wb_ack_o && busIdx > crs_pkg::IDX_ACC_MID) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_mid_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_14]
    (busWrite && busIdx == crs_pkg::IDX_ACC_MID && accWr.op == crs_pkg::ACC_NONE)
    |=> q.acc == $past(q.acc)) else $error("middle window write changed product");

  // -----------------------------------------------------------------
  // cover points
  // -----------------------------------------------------------------
  c_fast_take: cover property (@(posedge mclk) disable iff (!rst_n) fastIrqTake ##[1:20] fastIrqReturn);
  c_isp_zero_write: cover property (@(posedge mclk) disable iff (!rst_n)
    gprWr.we && gprWr.addr == 4'h0 && !threadSel);
  c_thread_stack_read: cover property (@(posedge mclk) disable iff (!rst_n) threadSel && gprRdAddrA == 4'h0);
  c_bus_write: cover property (@(posedge mclk) disable iff (!rst_n) busWrite);
  c_acc_split: cover property (@(posedge mclk) disable iff (!rst_n)
    accWr.op == crs_pkg::ACC_WR_HI ##1 accWr.op == crs_pkg::ACC_WR_LO);

endmodule : crs_register_set

//--- test/crs_core_model.sv
// core-side model: execution pipeline and interrupt controller facing the register set
`timescale 1ns/100ps
module crs_core_model (
  input  wire logic            mclk,
  input  wire logic [31:0]     gprRdDataA,
  input  wire logic [31:0]     gprRdDataB,
  output logic      [3:0]      gprRdAddrA,
  output logic      [3:0]      gprRdAddrB,
  output crs_pkg::crs_gpr_wr_s gprWr,
  output crs_pkg::crs_ctl_wr_s ctlWr,
  output crs_pkg::crs_acc_wr_s accWr,
  output logic                 fastIrqTake,
  output logic                 fastIrqReturn
);
  initial begin
    gprRdAddrA = 4'h0;
    gprRdAddrB = 4'h0;
    gprWr = '0;
    ctlWr = '0;
    accWr = '0;
    fastIrqTake = 1'b0;
    fastIrqReturn = 1'b0;
  end

  // each command stands one cycle; all tasks but rd end on the falling edge so results are settled
  task gw(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk) gprWr <= '{we: 1'b1, addr: a, data: d};
    @(posedge mclk) gprWr.we <= 1'b0;
    @(negedge mclk);
  endtask : gw

  task ctl(input crs_pkg::crs_ctl_e s, input logic [31:0] d);
    logic [31:0] v;
    // software keeps both stack copies word aligned
    v = (s == crs_pkg::CTL_ISP || s == crs_pkg::CTL_USP) ? {d[31:2], 2'h0} : d;
    @(posedge mclk) ctlWr <= '{we: 1'b1, sel: s, data: v};
    @(posedge mclk) ctlWr.we <= 1'b0;
    @(negedge mclk);
  endtask : ctl

  task acc(input crs_pkg::crs_acc_e o, input logic [63:0] d);
    @(posedge mclk) accWr <= '{op: o, data: d};
    @(posedge mclk) accWr.op <= crs_pkg::ACC_NONE;
    @(negedge mclk);
  endtask : acc

  task irq(input logic back);
    @(posedge mclk) fastIrqTake <= !back;
    fastIrqReturn <= back;
    @(posedge mclk) fastIrqTake <= 1'b0;
    fastIrqReturn <= 1'b0;
    @(negedge mclk);
  endtask : irq

  // port b looks at the mirror address so both read ports are exercised
  task rd(input logic [3:0] a, output logic [31:0] da, output logic [31:0] db);
    @(posedge mclk) gprRdAddrA <= a;
    gprRdAddrB <= 4'hF - a;
    @(posedge mclk);
    @(posedge mclk);
    da = gprRdDataA;
    db = gprRdDataB;
  endtask : rd
endmodule : crs_core_model

//--- test/tb.sv
// self-checking bench for the cpu register set over wishbone and core ports
`timescale 1ns/100ps
module tb;
  logic                 mclk;
  logic                 rst_n;
  logic                 cyc;
  logic                 stb;
  logic                 we;
  logic [7:0]           adr;
  logic [3:0]           sel;
  logic [31:0]          wdat;
  logic [31:0]          rdat;
  logic                 ack;
  logic [3:0]           addrA;
  logic [3:0]           addrB;
  logic [31:0]          dataA;
  logic [31:0]          dataB;
  crs_pkg::crs_gpr_wr_s gprWr;
  crs_pkg::crs_ctl_wr_s ctlWr;
  crs_pkg::crs_acc_wr_s accWr;
  logic                 take;
  logic                 back;
  logic [31:0]          vtb;
  logic [31:0]          ip;
  logic [31:0]          sw;
  logic [31:0]          accU;
  logic [31:0]          accM;
  logic [31:0]          r;
  logic [31:0]          a;
  logic [31:0]          b;
  int                   failures = 0;
  int                   checked = 0;
  int                   cycles = 0;

  crs_register_set dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .gprRdAddrA(addrA), .gprRdAddrB(addrB), .gprRdDataA(dataA), .gprRdDataB(dataB), .gprWr(gprWr),
    .ctlWr(ctlWr), .accWr(accWr), .fastIrqTake(take), .fastIrqReturn(back), .vectorTableBase(vtb),
    .instrPointer(ip), .statusWord(sw), .accUpperRead(accU), .accMiddleRead(accM));
  crs_core_model core (.mclk(mclk), .gprRdDataA(dataA), .gprRdDataB(dataB), .gprRdAddrA(addrA),
    .gprRdAddrB(addrB), .gprWr(gprWr), .ctlWr(ctlWr), .accWr(accWr), .fastIrqTake(take),
    .fastIrqReturn(back));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // whole run is well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end

  task end_sim();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [7:0] ba(input logic [4:0] i);
    return {1'b0, i, 2'b00};
  endfunction : ba

  // classic single cycle; no ack count assumed, only the cycle ceiling ends a hang
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s,
          output logic [31:0] q);
    @(posedge mclk) cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= s;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task t_reset();
    chk({ip, sw}, 64'h0);
    wb(1'b0, ba(crs_pkg::IDX_ISP), 32'h0, 4'h0, r);
    chk(r, crs_pkg::WORD_RESET);
  endtask : t_reset

  task t_gpr();
    for (int i = 1; i < 16; i++) core.gw(i[3:0], {16'hA5C3, 12'h000, i[3:0]});
    for (int i = 1; i < 15; i++) begin
      core.rd(i[3:0], a, b);
      chk(a, {16'hA5C3, 12'h000, i[3:0]});
      chk(b, {16'hA5C3, 12'h000, 4'hF - i[3:0]});
    end
    wb(1'b0, 8'h14, 32'h0, 4'h0, r);
    chk(r, 32'hA5C3_0005);
    // partial byte write merges into the old value
    wb(1'b1, 8'h28, 32'h1122_3344, 4'h5, r);
    core.rd(4'hA, a, b);
    chk(a, 32'hA522_0044);
  endtask : t_gpr

  task t_stack();
    core.ctl(crs_pkg::CTL_ISP, 32'h0000_0100);
    core.ctl(crs_pkg::CTL_USP, 32'h0000_0200);
    core.rd(4'h0, a, b);
    chk(a, 32'h0000_0100);
    core.ctl(crs_pkg::CTL_SW, 32'h1 << crs_pkg::SW_STACK_SEL_BIT);
    core.rd(4'h0, a, b);
    chk(a, 32'h0000_0200);
    core.gw(4'h0, 32'h0000_0300);
    wb(1'b0, ba(crs_pkg::IDX_USP), 32'h0, 4'h0, r);
    chk(r, 32'h0000_0300);
    wb(1'b0, ba(crs_pkg::IDX_ISP), 32'h0, 4'h0, r);
    chk(r, 32'h0000_0100);
    wb(1'b0, 8'h00, 32'h0, 4'h0, r);
    chk(r, 32'h0000_0300);
  endtask : t_stack

  task t_fast();
    core.ctl(crs_pkg::CTL_VTB, 32'h0000_8000);
    core.ctl(crs_pkg::CTL_IP, 32'h0000_1234);
    core.ctl(crs_pkg::CTL_FAST_IRQ_TARGET, 32'h0000_4000);
    core.ctl(crs_pkg::CTL_SW, 32'h0002_0005);
    chk(vtb, 32'h0000_8000);
    chk(ip, 32'h0000_1234);
    chk(sw, 32'h0002_0005);
    core.irq(1'b0);
    chk(ip, 32'h0000_4000);
    chk(sw[crs_pkg::SW_STACK_SEL_BIT], 1'b0);
    wb(1'b0, ba(crs_pkg::IDX_SIP), 32'h0, 4'h0, r);
    chk(r, 32'h0000_1234);
    wb(1'b0, ba(crs_pkg::IDX_SSW), 32'h0, 4'h0, r);
    chk(r, 32'h0002_0005);
    core.rd(4'h0, a, b);
    chk(a, 32'h0000_0100);
    core.gw(4'h0, 32'h0000_0180);
    wb(1'b0, ba(crs_pkg::IDX_ISP), 32'h0, 4'h0, r);
    chk(r, 32'h0000_0180);
    core.irq(1'b1);
    chk({ip, sw}, 64'h0000_1234_0002_0005);
    core.rd(4'h0, a, b);
    chk(a, 32'h0000_0300);
    core.ctl(crs_pkg::CTL_SIP, 32'h0000_2468);
    core.ctl(crs_pkg::CTL_SSW, 32'h0000_0003);
    core.irq(1'b1);
    chk({ip, sw}, 64'h0000_2468_0000_0003);
  endtask : t_fast

  task t_acc();
    core.acc(crs_pkg::ACC_PRODUCT, 64'h1122_3344_5566_7788);
    chk({accU, accM}, 64'h1122_3344_3344_5566);
    core.acc(crs_pkg::ACC_WR_HI, 64'h0000_0000_DEAD_BEEF);
    chk({accU, accM}, 64'hDEAD_BEEF_BEEF_5566);
    core.acc(crs_pkg::ACC_WR_LO, 64'hFFFF_FFFF_0BAD_F00D);
    chk(accM, 32'hBEEF_0BAD);
    // middle window is read only and an unmapped write lands nowhere
    wb(1'b1, ba(crs_pkg::IDX_ACC_MID), 32'h5A5A_5A5A, 4'hF, r);
    wb(1'b1, 8'h6C, 32'h5A5A_5A5A, 4'hF, r);
    wb(1'b0, ba(crs_pkg::IDX_ACC_MID), 32'h0, 4'h0, r);
    chk(r, 32'hBEEF_0BAD);
    wb(1'b0, ba(crs_pkg::IDX_ACC_LO), 32'h0, 4'h0, r);
    chk(r, 32'h0BAD_F00D);
    wb(1'b0, 8'h6C, 32'h0, 4'h0, r);
    chk(r, 32'h0);
    wb(1'b1, ba(crs_pkg::IDX_ACC_HI), 32'h1357_9BDF, 4'hF, r);
    @(negedge mclk);
    chk({accU, accM}, 64'h1357_9BDF_9BDF_0BAD);
    core.acc(crs_pkg::ACC_PRODUCT, 64'h0FED_CBA9_8765_4321);
    chk({accU, accM}, 64'h0FED_CBA9_CBA9_8765);
  endtask : t_acc

  task t_rerst();
    @(posedge mclk) rst_n <= 1'b0;
    @(posedge mclk) rst_n <= 1'b1;
    @(negedge mclk);
    chk({ip, accU}, 64'h0);
  endtask : t_rerst

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    t_reset();
    t_gpr();
    t_stack();
    t_fast();
    t_acc();
    t_rerst();
    end_sim();
  end
endmodule : tb
